// File: rtl/trsfl_consts.vh
// Constants for the display rail sequencer with fault latch.
// Assumes a 40 MHz clock and a 32-bit Avalon-MM register port.
`ifndef TRSFL_CONSTS_VH
`define TRSFL_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define TRSFL_CLK_NS 25
`define TRSFL_CLK_KHZ 40000
`define TRSFL_OSC_KHZ 400
`define TRSFL_SLOT_MS 15
`define TRSFL_UV_MS 50
`define TRSFL_EN_FILT_NS 7000
`define TRSFL_SHORT_NS 10000

// ****************************************************************
// Register map (byte addresses) and reset values
// ****************************************************************
`define TRSFL_REG_STATUS 4'h0
`define TRSFL_REG_CONTROL 4'h4
`define TRSFL_CONTROL_RESET 1'b0

// ****************************************************************
// Slot tables: {down4,down3,down2,down1,up4,up3,up2,up1} nibbles.
// Rail bits: 0 pos source, 1 neg source, 2 pos gate, 3 neg gate.
// ****************************************************************
`define TRSFL_SEQ_M0 32'h12844821
`define TRSFL_SEQ_M1 32'h12488421
`define TRSFL_SEQ_M2 32'h21844812
`define TRSFL_SEQ_M3 32'h01840481
`define TRSFL_SEQ_M4 32'h01480841
`define TRSFL_SEQ_M5 32'h300CC021
`define TRSFL_SEQ_M6 32'h84211248

`endif

// File: rtl/trsfl_top.v
// Rail sequencer, charge-pump switch control and fault latch.
// Assumes comparator inputs and pins are asynchronous to clk and that
// the sequence code arrives already decoded from the resistor sensor.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "trsfl_consts.vh"

module trsfl_top #(
  parameter SLOT_CYCLES = `TRSFL_SLOT_MS * `TRSFL_CLK_KHZ, // 15 ms
  parameter UV_CYCLES = `TRSFL_UV_MS * `TRSFL_CLK_KHZ // 50 ms
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire enable_pin,
  input wire [2:0] sequence_setting,
  input wire pos_gate_feedback_low,
  input wire neg_gate_feedback_high,
  input wire [3:0] rail_below_80,
  input wire [1:0] source_below_40,
  input wire pos_below_73_boost_high_input,
  input wire thermal_trip,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [3:0] rail_soft_start_enable,
  output reg pos_pump_high_switch,
  output reg pos_pump_low_switch,
  output reg neg_pump_high_switch,
  output reg neg_pump_low_switch,
  output reg pos_gate_discharge,
  output reg neg_gate_discharge,
  output reg pos_source_load_switch,
  output reg backlight_enable,
  output reg fault_latched,
  output reg thermal_latched
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam OSC_PERIOD = `TRSFL_CLK_KHZ / `TRSFL_OSC_KHZ;
  localparam OSC_HALF = OSC_PERIOD / 2;
  localparam EN_CYCLES =
    (`TRSFL_EN_FILT_NS + `TRSFL_CLK_NS - 1) / `TRSFL_CLK_NS;
  localparam SHORT_CYCLES =
    (`TRSFL_SHORT_NS + `TRSFL_CLK_NS - 1) / `TRSFL_CLK_NS;

  // Sequencer states.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_UP = 2'b01;
  localparam [1:0] ST_ON = 2'b10;
  localparam [1:0] ST_DOWN = 2'b11;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [12:0] sync_a; // First stage, read only by the second stage.
  reg [12:0] sync_b; // Second stage, safe for logic.
  wire [12:0] raw_in;

  assign raw_in = {thermal_trip, pos_below_73_boost_high_input,
                   source_below_40, rail_below_80,
                   neg_gate_feedback_high, pos_gate_feedback_low,
                   enable_pin, sequence_setting[1:0]};

  // Two flip-flops on every asynchronous input.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 13'h0000;
      sync_b <= 13'h0000;
    end else if (ce) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  reg seq2_a; // Top bit of the sequence code, first stage.
  reg seq2_b; // Top bit of the sequence code, second stage.

  // The sequence code top bit takes its own pair of flops.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq2_a <= 1'b0;
      seq2_b <= 1'b0;
    end else if (ce) begin
      seq2_a <= sequence_setting[2];
      seq2_b <= seq2_a;
    end
  end

  wire en_s = sync_b[2];
  wire pfb_low = sync_b[3];
  wire nfb_high = sync_b[4];
  wire [3:0] uv80 = sync_b[8:5];
  wire [1:0] sh40 = sync_b[10:9];
  wire below73 = sync_b[11];
  wire therm = sync_b[12];

  // ****************************************************************
  // Sequence code capture
  // ****************************************************************
  reg [2:0] seq_mode; // Held sequence code.
  reg seq_taken; // Set once the code has been captured.
  reg [1:0] settle; // Lets the synchronisers fill before capture.

  // Capture the code once, after the synchronisers have settled.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_mode <= 3'h0;
      seq_taken <= 1'b0;
      settle <= 2'h0;
    end else if (ce && !seq_taken) begin
      if (settle == 2'h3) begin
        seq_mode <= {seq2_b, sync_b[1:0]};
        seq_taken <= 1'b1;
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  // Slot table word for the held code.
  reg [31:0] seq_word;

  // Map the code onto its slot table; code 7 falls back to code 1.
  always @* begin
    case (seq_mode)
      3'h0: seq_word = `TRSFL_SEQ_M0;
      3'h1: seq_word = `TRSFL_SEQ_M1;
      3'h2: seq_word = `TRSFL_SEQ_M2;
      3'h3: seq_word = `TRSFL_SEQ_M3;
      3'h4: seq_word = `TRSFL_SEQ_M4;
      3'h5: seq_word = `TRSFL_SEQ_M5;
      3'h6: seq_word = `TRSFL_SEQ_M6;
      default: seq_word = `TRSFL_SEQ_M1;
    endcase
  end

  // ****************************************************************
  // Enable filter
  // ****************************************************************
  reg en_f; // Filtered enable.
  reg [8:0] en_cnt; // Time the raw level has differed.

  // The filtered level follows only after a steady disagreement.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_f <= 1'b0;
      en_cnt <= 9'h000;
    end else if (ce) begin
      if (en_s == en_f) begin
        en_cnt <= 9'h000;
      end else if (en_cnt == EN_CYCLES[8:0] - 9'h001) begin
        en_f <= en_s;
        en_cnt <= 9'h000;
      end else begin
        en_cnt <= en_cnt + 9'h001;
      end
    end
  end

  reg en_f_d; // Previous filtered enable, for edge detection.

  // Delay the filtered enable by one cycle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_f_d <= 1'b0;
    end else if (ce) begin
      en_f_d <= en_f;
    end
  end

  wire en_fall = en_f_d & ~en_f;

  // ****************************************************************
  // Undervoltage timers, one per rail, and short timers on the two source rails
  // ****************************************************************
  reg control_short73; // Enables the 73 percent short check.
  wire [3:0] uv_hit; // Rail has stayed low past the long limit.
  wire [1:0] sh_hit; // Source rail has stayed shorted.
  wire [1:0] sh_cond; // Short condition per source rail.

  assign sh_cond = {sh40[1], sh40[0] | (below73 & control_short73)};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_rail
      reg [21:0] uv_cnt; // Time this rail has been below 80 percent.
      reg [8:0] sh_cnt; // Time this rail has been shorted.

      // Count only while the rail is meant to be up.
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          uv_cnt <= 22'h000000;
          sh_cnt <= 9'h000;
        end else if (ce) begin
          if (rail_soft_start_enable[gi] && uv80[gi]) begin
            if (!uv_hit[gi]) begin
              uv_cnt <= uv_cnt + 22'h000001;
            end
          end else begin
            uv_cnt <= 22'h000000;
          end
          if (gi < 2 && rail_soft_start_enable[gi] && sh_cond[gi % 2]) begin
            if (sh_cnt != SHORT_CYCLES[8:0]) begin
              sh_cnt <= sh_cnt + 9'h001;
            end
          end else begin
            sh_cnt <= 9'h000;
          end
        end
      end

      assign uv_hit[gi] = (uv_cnt >= UV_CYCLES[21:0]);
      if (gi < 2) begin : g_src
        assign sh_hit[gi] = (sh_cnt == SHORT_CYCLES[8:0]);
      end
    end
  endgenerate

  // Rails that have faulted this cycle.
  wire [3:0] fault_rails = uv_hit | {2'b00, sh_hit};
  wire rail_fault = |fault_rails;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  reg [1:0] state; // Sequencer state.
  reg [21:0] slot_cnt; // Cycles within the current slot.
  reg [2:0] slot; // Slot number, 0 for the first slot to 3 for the last.
  reg [1:0] next_state;
  reg [3:0] next_rail;
  reg next_pdis;
  reg next_ndis;
  reg [3:0] slot_mask;
  wire slot_end = (slot_cnt == SLOT_CYCLES[21:0] - 22'h000001);

  // Next rail enables, discharges and state.
  always @* begin
    next_state = state;
    next_rail = rail_soft_start_enable;
    next_pdis = pos_gate_discharge;
    next_ndis = neg_gate_discharge;
    slot_mask = 4'h0;
    case (slot[1:0])
      2'h0: slot_mask = (state == ST_UP) ? seq_word[3:0] : seq_word[19:16];
      2'h1: slot_mask = (state == ST_UP) ? seq_word[7:4] : seq_word[23:20];
      2'h2: slot_mask = (state == ST_UP) ? seq_word[11:8] : seq_word[27:24];
      default: slot_mask = (state == ST_UP) ? seq_word[15:12] :
                           seq_word[31:28];
    endcase
    case (state)
      ST_IDLE: begin
        if (en_f && !fault_latched && !thermal_latched && seq_taken) begin
          next_state = ST_UP;
          next_pdis = 1'b0;
          next_ndis = 1'b0;
        end
      end
      ST_UP: begin
        if (slot_end) begin
          next_rail = next_rail | slot_mask;
          if (slot == 3'h3) begin
            next_state = ST_ON;
          end
        end
        if (!en_f) begin
          next_state = ST_DOWN;
        end
      end
      ST_ON: begin
        if (!en_f) begin
          next_state = ST_DOWN;
        end
      end
      default: begin
        if (slot_end) begin
          next_rail = next_rail & ~slot_mask;
          next_pdis = next_pdis | slot_mask[2];
          next_ndis = next_ndis | slot_mask[3];
          if (slot == 3'h3) begin
            next_state = ST_IDLE;
            next_rail = 4'h0;
          end
        end
      end
    endcase
    if (rail_fault) begin
      next_rail = next_rail & ~fault_rails;
      next_pdis = next_pdis | fault_rails[2];
      next_ndis = next_ndis | fault_rails[3];
      if (state == ST_UP || state == ST_ON) begin
        next_state = ST_DOWN;
      end
    end
    if (therm || thermal_latched) begin
      next_rail = 4'h0;
      next_pdis = 1'b1;
      next_ndis = 1'b1;
      next_state = ST_IDLE;
    end
  end

  // Register the sequencer and its rail outputs.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      slot_cnt <= 22'h000000;
      slot <= 3'h0;
      rail_soft_start_enable <= 4'h0;
      pos_gate_discharge <= 1'b1;
      neg_gate_discharge <= 1'b1;
      pos_source_load_switch <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      rail_soft_start_enable <= next_rail;
      pos_gate_discharge <= next_pdis;
      neg_gate_discharge <= next_ndis;
      pos_source_load_switch <= next_rail[0];
      if (next_state != state) begin
        slot_cnt <= 22'h000000; // Slots time from the state change.
        slot <= 3'h0;
      end else if (slot_end) begin
        slot_cnt <= 22'h000000;
        slot <= slot + 3'h1;
      end else begin
        slot_cnt <= slot_cnt + 22'h000001;
      end
    end
  end

  // ****************************************************************
  // Fault latches
  // ****************************************************************
  // Faults set over the enable-fall clear; only reset and enable clear.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_latched <= 1'b0;
      thermal_latched <= 1'b0;
      backlight_enable <= 1'b0;
    end else if (ce) begin
      if (rail_fault) begin
        fault_latched <= 1'b1;
      end else if (en_fall) begin
        fault_latched <= 1'b0;
      end
      if (therm) begin
        thermal_latched <= 1'b1;
      end else if (en_fall) begin
        thermal_latched <= 1'b0;
      end
      backlight_enable <= !(therm || thermal_latched);
    end
  end

  // ****************************************************************
  // Charge-pump oscillator and switch control
  // ****************************************************************
  reg [6:0] osc_cnt; // Shared oscillator phase.
  wire osc_rise = (osc_cnt == 7'h00);
  wire osc_fall = (osc_cnt == OSC_HALF[6:0]);

  // One oscillator steps both pumps.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt <= 7'h00;
    end else if (ce) begin
      if (osc_cnt == OSC_PERIOD[6:0] - 7'h01) begin
        osc_cnt <= 7'h00;
      end else begin
        osc_cnt <= osc_cnt + 7'h01;
      end
    end
  end

  // Pump switches; a disabled gate rail leaves both switches open.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_pump_high_switch <= 1'b0;
      pos_pump_low_switch <= 1'b0;
      neg_pump_high_switch <= 1'b0;
      neg_pump_low_switch <= 1'b0;
    end else if (ce) begin
      if (!next_rail[2]) begin
        pos_pump_high_switch <= 1'b0;
        pos_pump_low_switch <= 1'b0;
      end else if (osc_rise && pfb_low) begin
        pos_pump_high_switch <= 1'b1;
        pos_pump_low_switch <= 1'b0;
      end else if (osc_rise || osc_fall || !pos_pump_low_switch &&
                   !pos_pump_high_switch) begin
        pos_pump_high_switch <= 1'b0;
        pos_pump_low_switch <= 1'b1;
      end
      if (!next_rail[3]) begin
        neg_pump_high_switch <= 1'b0;
        neg_pump_low_switch <= 1'b0;
      end else if (osc_rise && nfb_high) begin
        neg_pump_low_switch <= 1'b1;
        neg_pump_high_switch <= 1'b0;
      end else if (osc_rise || osc_fall || !neg_pump_low_switch &&
                   !neg_pump_high_switch) begin
        neg_pump_low_switch <= 1'b0;
        neg_pump_high_switch <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Avalon-MM register slave
  // ****************************************************************
  wire [31:0] status_word = {17'h00000, seq_taken, seq_mode, en_f,
                             neg_gate_discharge, pos_gate_discharge,
                             thermal_latched, fault_latched, state,
                             rail_soft_start_enable};

  // Answer every request one cycle after it appears, then release.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      control_short73 <= `TRSFL_CONTROL_RESET;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            `TRSFL_REG_STATUS: avs_readdata <= status_word;
            `TRSFL_REG_CONTROL:
              avs_readdata <= {31'h00000000, control_short73};
            default: avs_readdata <= 32'h00000000;
          endcase
        end
      end else begin
        avs_waitrequest <= 1'b1;
        if (avs_write && !avs_waitrequest &&
            avs_address == `TRSFL_REG_CONTROL && avs_byteenable[0]) begin
          control_short73 <= avs_writedata[0];
        end
      end
    end
  end

endmodule // trsfl_top

// File: tb/tb_trsfl_top.sv
// Self-checking bench: all seven orders, glitch, faults, thermal trip.
// Assumes the short slot and undervoltage counts set at the instance.
`timescale 1ns/1ps

module tb_trsfl_top;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg enable_pin = 1'b0;
  reg [2:0] sequence_setting = 3'h0;
  reg thermal_trip = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [2:0] inj = 3'h0; // Fault injection into the far side.
  wire fb_lo, fb_hi, b73, avs_waitrequest, pos_gate_discharge;
  wire neg_gate_discharge, backlight_enable, fault_latched, thermal_latched;
  wire [3:0] rail_below_80, rail_soft_start_enable;
  wire [1:0] source_below_40;
  wire [31:0] avs_readdata;
  integer fails = 0;
  integer n_compared = 0;
  integer seed = 24;
  integer md, i;
  reg [31:0] q;

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clk = ~clk;

  trsfl_top #(.SLOT_CYCLES(200), .UV_CYCLES(300)) u_dut (.clk(clk),
    .rstn(rstn), .ce(1'b1), .enable_pin(enable_pin),
    .sequence_setting(sequence_setting), .pos_gate_feedback_low(fb_lo),
    .neg_gate_feedback_high(fb_hi), .rail_below_80(rail_below_80),
    .source_below_40(source_below_40), .pos_below_73_boost_high_input(b73),
    .thermal_trip(thermal_trip), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rail_soft_start_enable(rail_soft_start_enable),
    .pos_pump_high_switch(), .pos_pump_low_switch(),
    .neg_pump_high_switch(), .neg_pump_low_switch(),
    .pos_gate_discharge(pos_gate_discharge),
    .neg_gate_discharge(neg_gate_discharge), .pos_source_load_switch(),
    .backlight_enable(backlight_enable), .fault_latched(fault_latched),
    .thermal_latched(thermal_latched));

  trsfl_partner u_far (.clk(clk), .rstn(rstn),
    .rails(rail_soft_start_enable), .inj(inj),
    .pos_gate_feedback_low(fb_lo), .neg_gate_feedback_high(fb_hi),
    .rail_below_80(rail_below_80), .source_below_40(source_below_40),
    .pos_below_73_boost_high_input(b73));

  // Rail masks of power-up slots, slot one in the low nibble.
  function [15:0] up_tab(input [2:0] m);
    case (m)
      3'h0: up_tab = 16'h4821;
      3'h1: up_tab = 16'h8421;
      3'h2: up_tab = 16'h4812;
      3'h3: up_tab = 16'h0481;
      3'h4: up_tab = 16'h0841;
      3'h5: up_tab = 16'hC021;
      default: up_tab = 16'h1248;
    endcase
  endfunction

  // Rail masks of power-down slots, slot one in the low nibble.
  function [15:0] dn_tab(input [2:0] m);
    case (m)
      3'h0: dn_tab = 16'h1284;
      3'h1: dn_tab = 16'h1248;
      3'h2: dn_tab = 16'h2184;
      3'h3: dn_tab = 16'h0184;
      3'h4: dn_tab = 16'h0148;
      3'h5: dn_tab = 16'h300C;
      default: dn_tab = 16'h8421;
    endcase
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Compares one observed value with its expectation.
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low.
  task bus(input w, input [3:0] a, input [31:0] d, output [31:0] r);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      // Only the watchdog may end this wait; a silent slave is a failure.
      while (avs_waitrequest !== 1'b0) begin
        @(posedge clk);
      end
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Resets with a new sequence code and lets it be captured.
  task rst_dut(input [2:0] m);
    begin
      rstn <= 1'b0;
      sequence_setting <= m;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask

  // Waits for the first slot, then checks every slot at mid-slot.
  task walk(input [15:0] s, input [3:0] start, input up);
    integer k;
    reg [3:0] m;
    begin
      m = start;
      i = 0;
      while (rail_soft_start_enable === start && i < 2000) begin
        @(posedge clk);
        i = i + 1;
      end
      repeat (100) @(posedge clk);
      for (k = 0; k < 4; k = k + 1) begin
        m = up ? (m | s[4*k +: 4]) : (m & ~s[4*k +: 4]);
        check(rail_soft_start_enable, m);
        repeat (200) @(posedge clk);
      end
    end
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (60000) @(posedge clk);
    fails = fails + 1;
    stop_test;
  end

  // Main sequence: one pass per sequence code from 0 to 6.
  initial begin
    for (md = 0; md < 7; md = md + 1) begin
      rst_dut(md[2:0]);
      bus(1'b0, 4'h0, 32'h0, q);
      check({q[14:11], q[3:0]}, {1'b1, md[2:0], 4'h0});
      bus(1'b0, 4'h8, 32'h0, q);
      check(q, 32'h0);
      if (md == 0) begin
        enable_pin <= 1'b1;
        repeat (20 + {$random(seed)} % 240) @(posedge clk);
        enable_pin <= 1'b0;
        repeat (900) @(posedge clk);
        check(rail_soft_start_enable, 4'h0);
      end
      enable_pin <= 1'b1;
      walk(up_tab(md[2:0]), 4'h0, 1'b1);
      if (md == 1 || md == 2) begin
        if (md == 1) begin
          bus(1'b1, 4'h4, 32'h1, q);
          bus(1'b0, 4'h4, 32'h0, q);
          check(q[0], 1'b1);
        end
        inj <= (md == 1) ? 3'h4 : 3'h2;
        i = 0;
        while (fault_latched !== 1'b1 && i < 1000) begin
          @(posedge clk);
          i = i + 1;
        end
        check(rail_soft_start_enable[md - 1], 1'b0);
        check({fault_latched, backlight_enable}, 2'h3);
        inj <= 3'h0;
        repeat (900) @(posedge clk);
        check({fault_latched, rail_soft_start_enable}, 5'h10);
        enable_pin <= 1'b0;
        repeat (400) @(posedge clk);
        check(fault_latched, 1'b0);
      end else if (md == 3) begin
        thermal_trip <= 1'b1;
        repeat (10) @(posedge clk);
        check({thermal_latched, backlight_enable}, 2'h2);
        check(rail_soft_start_enable, 4'h0);
        thermal_trip <= 1'b0;
        repeat (50) @(posedge clk);
        check(thermal_latched, 1'b1);
        enable_pin <= 1'b0;
        repeat (400) @(posedge clk);
        check(thermal_latched, 1'b0);
      end else begin
        enable_pin <= 1'b0;
        q[15:0] = up_tab(md[2:0]);
        walk(dn_tab(md[2:0]), q[15:12] | q[11:8] | q[7:4] | q[3:0], 1'b0);
        check({pos_gate_discharge, neg_gate_discharge}, 2'h3);
      end
      $display("test with sequence code %0d done", md);
    end
    stop_test;
  end
endmodule // tb_trsfl_top

// File: tb/trsfl_monitor.sv
// Checker for the rail sequencer top ports, bound below.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps

module trsfl_monitor (
  input wire clk,
  input wire rstn,
  input wire enable_pin,
  input wire pos_gate_feedback_low,
  input wire neg_gate_feedback_high,
  input wire thermal_trip,
  input wire [3:0] rail_soft_start_enable,
  input wire pos_pump_high_switch,
  input wire pos_pump_low_switch,
  input wire neg_pump_high_switch,
  input wire neg_pump_low_switch,
  input wire pos_gate_discharge,
  input wire neg_gate_discharge,
  input wire pos_source_load_switch,
  input wire backlight_enable,
  input wire fault_latched,
  input wire thermal_latched
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_POS_EXCL: assert property (!(pos_pump_high_switch && pos_pump_low_switch))
    else $error("positive pump switches on together");
  AST_NEG_EXCL: assert property (!(neg_pump_high_switch && neg_pump_low_switch))
    else $error("negative pump switches on together");
  AST_POS_SKIP: assert property ((!pos_gate_feedback_low)[*8] |-> !$rose(pos_pump_high_switch))
    else $error("positive pump fired with feedback high");
  AST_NEG_SKIP: assert property ((!neg_gate_feedback_high)[*8] |-> !$rose(neg_pump_low_switch))
    else $error("negative pump fired with feedback low");
  AST_THERMAL: assert property (thermal_trip[*3] |-> ##[0:6] (rail_soft_start_enable == 4'h0 && !backlight_enable))
    else $error("thermal trip left outputs running");
  AST_FAULT_HOLD: assert property ($fell(fault_latched) |-> !enable_pin)
    else $error("rail fault released with enable high");
  AST_THERM_HOLD: assert property ($fell(thermal_latched) |-> !enable_pin)
    else $error("thermal fault released with enable high");
  AST_LOAD: assert property (pos_source_load_switch == rail_soft_start_enable[0])
    else $error("load switch differs from positive source");
  AST_BACKLIGHT: assert property ((!thermal_trip)[*4] ##0 (fault_latched && !thermal_latched) |-> backlight_enable)
    else $error("rail fault stopped the backlight");
  AST_START: assert property ($rose(|rail_soft_start_enable) |-> enable_pin)
    else $error("rail started with enable low");
  AST_DIS_POS: assert property ($fell(rail_soft_start_enable[2]) |-> ##[0:2] pos_gate_discharge)
    else $error("positive gate discharge missing");
  AST_DIS_NEG: assert property ($fell(rail_soft_start_enable[3]) |-> ##[0:2] neg_gate_discharge)
    else $error("negative gate discharge missing");
endmodule // trsfl_monitor

bind trsfl_top trsfl_monitor u_mon (.clk(clk), .rstn(rstn),
  .enable_pin(enable_pin), .pos_gate_feedback_low(pos_gate_feedback_low),
  .neg_gate_feedback_high(neg_gate_feedback_high),
  .thermal_trip(thermal_trip),
  .rail_soft_start_enable(rail_soft_start_enable),
  .pos_pump_high_switch(pos_pump_high_switch),
  .pos_pump_low_switch(pos_pump_low_switch),
  .neg_pump_high_switch(neg_pump_high_switch),
  .neg_pump_low_switch(neg_pump_low_switch),
  .pos_gate_discharge(pos_gate_discharge),
  .neg_gate_discharge(neg_gate_discharge),
  .pos_source_load_switch(pos_source_load_switch),
  .backlight_enable(backlight_enable), .fault_latched(fault_latched),
  .thermal_latched(thermal_latched));

// File: tb/trsfl_partner.sv
// Far-side model: power stages, comparators and feedback pins.
// Assumes the rail enables of the sequencer; faults are injected.
`timescale 1ns/1ps

module trsfl_partner (
  input wire clk,
  input wire rstn,
  input wire [3:0] rails,
  input wire [2:0] inj,
  output wire pos_gate_feedback_low,
  output wire neg_gate_feedback_high,
  output wire [3:0] rail_below_80,
  output wire [1:0] source_below_40,
  output wire pos_below_73_boost_high_input
);
  reg [9:0] cnt; // Slow pattern for both feedback comparators.
  reg [31:0] pipe; // Eight cycles of rail enable history.
  wire [3:0] good; // A rail counts as settled after eight cycles.

  // Each enabled rail ramps for eight cycles, then holds regulation.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 10'h000;
      pipe <= 32'h0;
    end else begin
      cnt <= cnt + 10'h001;
      pipe <= {pipe[27:0], rails};
    end
  end
  assign good = rails & pipe[31:28];
  assign pos_gate_feedback_low = cnt[9];
  assign neg_gate_feedback_high = cnt[8];
  assign rail_below_80 = ~good;
  assign source_below_40 = ~good[1:0] | inj[1:0];
  assign pos_below_73_boost_high_input = inj[2];
endmodule // trsfl_partner
